//--- logic/pmp_pkg.sv
// Shared constants and state types of the interrupt controller pair and its host
package pmp_pkg;

	// ----------------------------------------------------------------
	// I/O bus widths and addresses
	// ----------------------------------------------------------------
	localparam int        IO_AW         = 12;
	localparam int        IO_DW         = 8;
	localparam logic [11:0] ADDR_CMD_MST  = 12'h020;
	localparam logic [11:0] ADDR_DATA_MST = 12'h021;
	localparam logic [11:0] ADDR_CMD_SLV  = 12'h0a0;
	localparam logic [11:0] ADDR_DATA_SLV = 12'h0a1;
	localparam logic [11:0] ADDR_TRIG     = 12'h4d0;

	// ----------------------------------------------------------------
	// Command word fields
	// ----------------------------------------------------------------
	localparam int        BIT_RSVD      = 7;
	localparam int        BIT_SPEC_MASK = 6;
	localparam int        BIT_SPEC_WREN = 5;
	localparam int        SEL_HI        = 4;
	localparam int        SEL_LO        = 3;
	localparam int        BIT_POLL      = 2;
	localparam int        BIT_RD_CMD    = 1;
	localparam int        BIT_RD_INSVC  = 0;
	localparam logic [1:0] SEL_THIRD     = 2'h1;
	localparam logic [1:0] SEL_SECOND    = 2'h0;
	localparam logic [7:0] CMD_RESET     = 8'h22;

	// ----------------------------------------------------------------
	// Trigger select register
	// ----------------------------------------------------------------
	localparam int        TRIG_LSB      = 3;
	localparam logic [7:0] TRIG_RESET    = 8'h00;
	localparam logic [7:0] TRIG_RSVD     = 8'h07;

	// ----------------------------------------------------------------
	// Host register offsets and status layout
	// ----------------------------------------------------------------
	localparam logic [7:0] HR_IOADDR     = 8'h00;
	localparam logic [7:0] HR_WRITE      = 8'h04;
	localparam logic [7:0] HR_READ       = 8'h08;
	localparam logic [7:0] HR_STATUS     = 8'h0c;
	localparam logic [7:0] HR_CLEAR      = 8'h10;
	localparam logic [7:0] HR_ENABLE     = 8'h14;
	localparam logic [7:0] HR_CTRL       = 8'h18;
	localparam int        EV_WR_DONE    = 0;
	localparam int        EV_RD_DONE    = 1;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0][7:0] cmdImg;
		logic [1:0]      pollPend;
		logic [4:0]      trigSel;
		logic [15:0]     reqLatch;
		logic [15:0]     linePrev;
		logic [7:0]      rdData;
	} pmp_dev_st_t;

	localparam pmp_dev_st_t DEV_ST_RESET = '{
		cmdImg:  {CMD_RESET, CMD_RESET},
		trigSel: TRIG_RESET[7:3],
		default: '0
	};

	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_ISSUE = 2'h1,
		HS_CAPT  = 2'h3,
		HS_DONE  = 2'h2
	} pmp_hstate_t;

	typedef struct packed {
		pmp_hstate_t state;
		logic        isRead;
		logic        keepSel;
		logic [11:0] ioAddr;
		logic [7:0]  ioWrData;
		logic        ioWr;
		logic        ioRd;
		logic [7:0]  lastRd;
		logic [1:0]  status;
		logic [1:0]  enable;
		logic [31:0] regRdData;
	} pmp_host_st_t;

	localparam pmp_host_st_t HOST_ST_RESET = '{state: HS_IDLE, default: '0};

endpackage : pmp_pkg

//--- logic/pmp_io_if.sv
// I/O cycle interface between host processor end and controller pair
`timescale 1ns/100ps
interface pmp_io_if;
	logic [11:0] ioAddr;
	logic [7:0]  ioWrData;
	logic        ioWr;
	logic        ioRd;
	logic [7:0]  ioRdData;

	modport dev (
		input  ioAddr,
		input  ioWrData,
		input  ioWr,
		input  ioRd,
		output ioRdData
	);

	modport host (
		output ioAddr,
		output ioWrData,
		output ioWr,
		output ioRd,
		input  ioRdData
	);
endinterface : pmp_io_if

//--- logic/pmp_pic_device.sv
// Master and slave interrupt controller: status/mask/poll command and trigger select
`timescale 1ns/100ps
module pmp_pic_device (
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// I/O bus
	pmp_io_if.dev            io,
	// Interrupt lines and latches of the priority core
	input  wire logic [15:0] irqIn,
	input  wire logic [15:0] maskIn,
	input  wire logic [15:0] inServiceIn,
	// Controller interrupt outputs
	output logic      [1:0]  intReq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] prioEnc(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : prioEnc

	function automatic logic [7:0] aboveMask(input logic [3:0] p);
		logic [7:0] m;
		m = 8'hff;
		if (p[3]) begin
			m = (8'h01 << p[2:0]) - 8'h01;
		end
		return m;
	endfunction : aboveMask

	function automatic logic [7:0] byteOf(input logic [15:0] v, input int c);
		logic [7:0] b;
		b = v[c*8 +: 8];
		return b;
	endfunction : byteOf

	function automatic logic isThird(input logic [7:0] w);
		logic hit;
		hit = (w[pmp_pkg::SEL_HI:pmp_pkg::SEL_LO] == pmp_pkg::SEL_THIRD);
		return hit;
	endfunction : isThird

	function automatic logic [7:0] pollWord(input logic [3:0] b);
		logic [7:0] w;
		w = {b[3], 4'h0, b[2:0]};
		return w;
	endfunction : pollWord

	function automatic logic reqNext(input logic lvl, input logic pin, input logic prev,
		input logic msk, input logic ack, input logic cur);
		logic r;
		r = cur;
		if (lvl) begin
			r = pin & ~msk;
		end else if (!pin) begin
			r = 1'b0;
		end else if (!prev && !msk) begin
			r = 1'b1;
		end else if (ack) begin
			r = 1'b0;
		end
		return r;
	endfunction : reqNext

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pmp_pkg::pmp_dev_st_t st_ff;
	pmp_pkg::pmp_dev_st_t nxt_st;

	logic [1:0]  cmdHit;
	logic [1:0]  dataHit;
	logic        trigHit;
	logic [7:0]  elig [2];
	logic [3:0]  best [2];
	logic [15:0] lineIn;
	logic [15:0] lvlSel;
	logic [1:0]  thirdWr;
	logic [1:0]  ctlRd;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign cmdHit[0]  = (io.ioAddr == pmp_pkg::ADDR_CMD_MST);
	assign cmdHit[1]  = (io.ioAddr == pmp_pkg::ADDR_CMD_SLV);
	assign dataHit[0] = (io.ioAddr == pmp_pkg::ADDR_DATA_MST);
	assign dataHit[1] = (io.ioAddr == pmp_pkg::ADDR_DATA_SLV);
	assign trigHit    = (io.ioAddr == pmp_pkg::ADDR_TRIG);
	assign thirdWr[0] = io.ioWr && cmdHit[0] && isThird(io.ioWrData);
	assign thirdWr[1] = io.ioWr && cmdHit[1] && isThird(io.ioWrData);
	assign ctlRd[0]   = io.ioRd && (cmdHit[0] || dataHit[0]);
	assign ctlRd[1]   = io.ioRd && (cmdHit[1] || dataHit[1]);

	// ----------------------------------------------------------------
	// Priority and cascade
	// ----------------------------------------------------------------
	for (genvar c = 0; c < 2; c++) begin : g_ctl
		assign elig[c] = byteOf(st_ff.reqLatch, c) & ~byteOf(maskIn, c)
			& (st_ff.cmdImg[c][pmp_pkg::BIT_SPEC_MASK] ? 8'hff
			: aboveMask(prioEnc(byteOf(inServiceIn, c))));
		assign best[c]   = prioEnc(elig[c]);
		assign intReq[c] = best[c][3];
	end

	assign lineIn = {irqIn[15:3], irqIn[2] | intReq[1], irqIn[1:0]};
	assign lvlSel = {8'h00, st_ff.trigSel, 3'h0};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0]  cmd;
		logic [7:0]  wd;
		logic [15:0] ackClr;
		logic [3:0]  idx;
		cmd    = 8'h00;
		wd     = io.ioWrData;
		ackClr = 16'h0000;
		idx    = 4'h0;
		nxt_st = st_ff;
		nxt_st.rdData = 8'h00;

		for (int c = 0; c < 2; c++) begin
			cmd = st_ff.cmdImg[c];
			if (thirdWr[c]) begin
				if (wd[pmp_pkg::BIT_SPEC_WREN]) begin
					cmd[pmp_pkg::BIT_SPEC_MASK] = wd[pmp_pkg::BIT_SPEC_MASK];
				end
				cmd[pmp_pkg::BIT_SPEC_WREN] = wd[pmp_pkg::BIT_SPEC_WREN];
				nxt_st.pollPend[c] = wd[pmp_pkg::BIT_POLL];
				if (wd[pmp_pkg::BIT_RD_CMD]) begin
					cmd[pmp_pkg::BIT_RD_CMD:pmp_pkg::BIT_RD_INSVC]
						= wd[pmp_pkg::BIT_RD_CMD:pmp_pkg::BIT_RD_INSVC];
				end
			end
			// Select code 00 (rotate and end-of-interrupt) is ignored here; no logic handles it
			nxt_st.cmdImg[c] = cmd;

			if (ctlRd[c]) begin
				if (st_ff.pollPend[c]) begin
					// Poll read acts as acknowledge of the top request
					nxt_st.rdData      = pollWord(best[c]);
					nxt_st.pollPend[c] = 1'b0;
					idx                = {1'(c), best[c][2:0]};
					ackClr[idx]        = best[c][3];
				end else if (dataHit[c]) begin
					nxt_st.rdData = byteOf(maskIn, c);
				end else if (st_ff.cmdImg[c][pmp_pkg::BIT_RD_INSVC]) begin
					nxt_st.rdData = byteOf(inServiceIn, c);
				end else begin
					nxt_st.rdData = byteOf(st_ff.reqLatch, c);
				end
			end
		end

		if (io.ioWr && trigHit) begin
			nxt_st.trigSel = wd[7:pmp_pkg::TRIG_LSB];
		end
		if (io.ioRd && trigHit) begin
			nxt_st.rdData = {st_ff.trigSel, 3'h0};
		end

		for (int i = 0; i < 16; i++) begin
			nxt_st.reqLatch[i] = reqNext(lvlSel[i], lineIn[i], st_ff.linePrev[i], maskIn[i],
				ackClr[i], st_ff.reqLatch[i]);
		end
		nxt_st.linePrev = lineIn;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_ff <= pmp_pkg::DEV_ST_RESET;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign io.ioRdData = st_ff.rdData;

endmodule : pmp_pic_device

//--- logic/pmp_host_ctrl.sv
// Host processor end: turns register orders into single I/O cycles
`timescale 1ns/100ps
module pmp_host_ctrl (
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdData,
	// Interrupt
	output logic             irq,
	// I/O bus
	pmp_io_if.host           io
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] fixWrite(input logic [11:0] a, input logic [7:0] d,
		input logic keep);
		logic [7:0] r;
		r = d;
		if ((a == pmp_pkg::ADDR_CMD_MST || a == pmp_pkg::ADDR_CMD_SLV)
			&& d[pmp_pkg::SEL_HI:pmp_pkg::SEL_LO] == pmp_pkg::SEL_THIRD) begin
			r[pmp_pkg::BIT_RSVD] = 1'b0;
			if (keep) begin
				r[pmp_pkg::BIT_RD_CMD] = 1'b0;
			end
		end
		if (a == pmp_pkg::ADDR_TRIG) begin
			r = r & ~pmp_pkg::TRIG_RSVD;
		end
		return r;
	endfunction : fixWrite

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pmp_pkg::pmp_host_st_t st_ff;
	pmp_pkg::pmp_host_st_t nxt_st;

	always_comb begin
		logic [1:0] setEv;
		logic [1:0] clrEv;
		setEv  = 2'h0;
		clrEv  = 2'h0;
		nxt_st = st_ff;
		nxt_st.ioWr      = 1'b0;
		nxt_st.ioRd      = 1'b0;
		nxt_st.regRdData = 32'h0000_0000;

		unique case (st_ff.state)
			pmp_pkg::HS_IDLE: begin
				if (regWr && (regAddr == pmp_pkg::HR_WRITE || regAddr == pmp_pkg::HR_READ)) begin
					nxt_st.isRead = (regAddr == pmp_pkg::HR_READ);
					nxt_st.ioWr   = (regAddr == pmp_pkg::HR_WRITE);
					nxt_st.ioRd   = (regAddr == pmp_pkg::HR_READ);
					if (regAddr == pmp_pkg::HR_WRITE) begin
						nxt_st.ioWrData = fixWrite(st_ff.ioAddr, regWrData[7:0], st_ff.keepSel);
					end
					nxt_st.state  = pmp_pkg::HS_ISSUE;
				end
			end
			pmp_pkg::HS_ISSUE: begin
				nxt_st.state = pmp_pkg::HS_CAPT;
			end
			pmp_pkg::HS_CAPT: begin
				if (st_ff.isRead) begin
					nxt_st.lastRd = io.ioRdData;
				end
				nxt_st.state = pmp_pkg::HS_DONE;
			end
			pmp_pkg::HS_DONE: begin
				setEv[pmp_pkg::EV_RD_DONE] = st_ff.isRead;
				setEv[pmp_pkg::EV_WR_DONE] = !st_ff.isRead;
				nxt_st.state = pmp_pkg::HS_IDLE;
			end
		endcase

		if (regWr) begin
			unique case (regAddr)
				pmp_pkg::HR_IOADDR: begin
					if (st_ff.state == pmp_pkg::HS_IDLE) begin
						nxt_st.ioAddr = regWrData[11:0];
					end
				end
				pmp_pkg::HR_CLEAR:  clrEv          = regWrData[1:0];
				pmp_pkg::HR_ENABLE: nxt_st.enable  = regWrData[1:0];
				pmp_pkg::HR_CTRL:   nxt_st.keepSel = regWrData[0];
				default: ;
			endcase
		end
		nxt_st.status = (st_ff.status & ~clrEv) | setEv;

		if (regRd) begin
			unique case (regAddr)
				pmp_pkg::HR_IOADDR: nxt_st.regRdData = {20'h0_0000, st_ff.ioAddr};
				pmp_pkg::HR_WRITE:  nxt_st.regRdData = {24'h00_0000, st_ff.ioWrData};
				pmp_pkg::HR_READ:   nxt_st.regRdData = {24'h00_0000, st_ff.lastRd};
				pmp_pkg::HR_STATUS: nxt_st.regRdData = {29'h0000_0000,
					st_ff.state != pmp_pkg::HS_IDLE, st_ff.status};
				pmp_pkg::HR_ENABLE: nxt_st.regRdData = {30'h0000_0000, st_ff.enable};
				pmp_pkg::HR_CTRL:   nxt_st.regRdData = {31'h0000_0000, st_ff.keepSel};
				default:            nxt_st.regRdData = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_ff <= pmp_pkg::HOST_ST_RESET;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign regRdData   = st_ff.regRdData;
	assign irq         = |(st_ff.status & st_ff.enable);
	assign io.ioAddr   = st_ff.ioAddr;
	assign io.ioWrData = st_ff.ioWrData;
	assign io.ioWr     = st_ff.ioWr;
	assign io.ioRd     = st_ff.ioRd;

endmodule : pmp_host_ctrl

//--- bench/pmp_asserts.sv
// Assertions on the I/O cycle interface between the two ends
`timescale 1ns/100ps
module pmp_asserts (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// I/O bus
	input wire logic [11:0] ioAddr,
	input wire logic [7:0]  ioWrData,
	input wire logic        ioWr,
	input wire logic        ioRd,
	input wire logic [7:0]  ioRdData
);
	// --------
	// Shadow state
	// --------
	logic [7:0] trigCopy_ff;
	logic       pollArm_ff;
	logic       isMapped;
	logic       cmdWr;
	assign isMapped = ioAddr inside {pmp_pkg::ADDR_CMD_MST, pmp_pkg::ADDR_DATA_MST,
		pmp_pkg::ADDR_CMD_SLV, pmp_pkg::ADDR_DATA_SLV, pmp_pkg::ADDR_TRIG};
	assign cmdWr = ioWr && ioAddr == pmp_pkg::ADDR_CMD_MST && ioWrData[4:3] == 2'h1;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			trigCopy_ff <= 8'h00;
			pollArm_ff  <= 1'b0;
		end else begin
			if (ioWr && ioAddr == pmp_pkg::ADDR_TRIG) begin
				trigCopy_ff <= ioWrData;
			end
			if (ioRd && ioAddr[11:1] == 11'h010) begin
				pollArm_ff <= 1'b0;
			end else if (cmdWr) begin
				pollArm_ff <= ioWrData[2];
			end
		end
	end
	// --------
	// Properties
	// --------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_strobe_excl: assert property (!(ioWr && ioRd))
		else $error("both strobes high");
	a_wr_single: assert property (ioWr |=> !ioWr)
		else $error("write strobe too long");
	a_data_idle: assert property (!ioRd |=> ioRdData == 8'h00)
		else $error("read data outside answer cycle");
	a_unmapped_zero: assert property (ioRd && !isMapped |=> ioRdData == 8'h00)
		else $error("unmapped read not zero");
	a_trig_readback: assert property (ioRd && ioAddr == pmp_pkg::ADDR_TRIG
		|=> ioRdData == {trigCopy_ff[7:3], 3'h0}) else $error("trigger readback wrong");
	a_trig_wr_clean: assert property (ioWr && ioAddr == pmp_pkg::ADDR_TRIG
		|-> ioWrData[2:0] == 3'h0) else $error("trigger low bits written");
	a_cmd_rsvd_zero: assert property (cmdWr |-> !ioWrData[7])
		else $error("command bit 7 written");
	a_poll_reply: assert property (ioRd && pollArm_ff && ioAddr == pmp_pkg::ADDR_CMD_MST
		|=> ioRdData[6:3] == 4'h0) else $error("poll reply malformed");
	c_poll: cover property (ioRd && pollArm_ff);
	c_trig_rd: cover property (ioRd && ioAddr == pmp_pkg::ADDR_TRIG);
	c_spec_mask: cover property (cmdWr && ioWrData[6:5] == 2'h3);
endmodule : pmp_asserts

//--- bench/test_pic_mask_poll_trigger_ctrl.sv
// Self-checking bench joining the host end to the controller pair
`timescale 1ns/100ps
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin numErrors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_pic_mask_poll_trigger_ctrl;
	logic        sys_clk;
	logic        reset;
	logic [7:0]  regAddr;
	logic [31:0] regWrData;
	logic        regWr;
	logic        regRd;
	logic        ce;
	logic [31:0] regRdData;
	logic        irq;
	logic [15:0] irqIn;
	logic [15:0] maskIn;
	logic [15:0] inServiceIn;
	logic [1:0]  intReq;
	logic [7:0]  rd;
	logic [31:0] s;
	int          numErrors;
	int          checkCount;
	// --------
	// Ends, link and checker
	// --------
	pmp_io_if io ();
	pmp_host_ctrl i_pmp_host_ctrl (.sys_clk(sys_clk), .reset(reset), .ce(ce),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .irq(irq), .io(io.host));
	pmp_pic_device i_pmp_pic_device (.sys_clk(sys_clk), .reset(reset), .ce(ce),
		.io(io.dev), .irqIn(irqIn), .maskIn(maskIn), .inServiceIn(inServiceIn),
		.intReq(intReq));
	pmp_asserts i_pmp_asserts (.sys_clk(sys_clk), .reset(reset), .ioAddr(io.ioAddr),
		.ioWrData(io.ioWrData), .ioWr(io.ioWr), .ioRd(io.ioRd), .ioRdData(io.ioRdData));
	// --------
	// Register port and I/O cycles
	// --------
	task automatic regW(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : regW
	task automatic regR(input logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 s = regRdData;
	endtask : regR
	task automatic waitDone(input int b);
		int n;
		n = 0;
		do begin
			regR(pmp_pkg::HR_STATUS);
			n++;
		end while (s[b] !== 1'b1 && n < 20);
		`CHK("done", 1'b1, s[b]);
	endtask : waitDone
	task automatic ioW(input logic [11:0] a, input logic [7:0] d);
		regW(pmp_pkg::HR_IOADDR, {20'h0, a});
		regW(pmp_pkg::HR_WRITE, {24'h0, d});
		waitDone(pmp_pkg::EV_WR_DONE);
		regW(pmp_pkg::HR_CLEAR, 32'h3);
	endtask : ioW
	task automatic ioR(input logic [11:0] a);
		regW(pmp_pkg::HR_IOADDR, {20'h0, a});
		regW(pmp_pkg::HR_READ, 32'h0);
		waitDone(pmp_pkg::EV_RD_DONE);
		regR(pmp_pkg::HR_READ);
		rd = s[7:0];
		regW(pmp_pkg::HR_CLEAR, 32'h3);
	endtask : ioR
	// --------
	// Scenarios
	// --------
	task automatic t_defaults;
		@(posedge sys_clk);
		maskIn <= 16'hc35a;
		ioR(pmp_pkg::ADDR_DATA_MST);
		`CHK("maskMst", 8'h5a, rd);
		ioR(pmp_pkg::ADDR_DATA_SLV);
		`CHK("maskSlv", 8'hc3, rd);
		ioR(pmp_pkg::ADDR_TRIG);
		`CHK("trigRst", 8'h00, rd);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("selRst", 8'h00, rd);
		ioR(12'h123);
		`CHK("unmapped", 8'h00, rd);
		maskIn <= 16'h0000;
	endtask : t_defaults
	task automatic t_select;
		ioW(pmp_pkg::ADDR_CMD_MST, 8'h0b);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("selIsr", 8'h81, rd);
		ioW(pmp_pkg::ADDR_CMD_MST, 8'h09);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("selNoAct", 8'h81, rd);
		ioW(pmp_pkg::ADDR_CMD_MST, 8'h02);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("selOther", 8'h81, rd);
		ioR(pmp_pkg::ADDR_CMD_SLV);
		`CHK("slvIrr", 8'h00, rd);
		ioW(pmp_pkg::ADDR_CMD_SLV, 8'h0b);
		ioR(pmp_pkg::ADDR_CMD_SLV);
		`CHK("slvIsr", 8'h24, rd);
		ioW(pmp_pkg::ADDR_CMD_MST, 8'h0a);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("selIrr", 8'h00, rd);
		regW(pmp_pkg::HR_CTRL, 32'h1);
		ioW(pmp_pkg::ADDR_CMD_MST, 8'h0b);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("keepSel", 8'h00, rd);
		regW(pmp_pkg::HR_CTRL, 32'h0);
	endtask : t_select
	task automatic lvlChk(input logic [7:0] t, input logic [7:0] e);
		ioW(pmp_pkg::ADDR_TRIG, t);
		ioR(pmp_pkg::ADDR_TRIG);
		`CHK("trigRd", e, rd);
		maskIn <= 16'h00fa;
		irqIn  <= 16'h00fa;
		repeat (3) @(posedge sys_clk);
		maskIn <= 16'h0000;
		repeat (3) @(posedge sys_clk);
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("reqLatch", e, rd);
		irqIn <= 16'h0000;
	endtask : lvlChk
	task automatic t_poll;
		logic [7:0] cmds [5] = '{8'h0c, 8'h6c, 8'h4c, 8'h2c, 8'h4c};
		logic       ok   [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		@(posedge sys_clk);
		inServiceIn <= 16'h0002;
		for (int i = 0; i < 5; i++) begin
			irqIn <= 16'h0000;
			repeat (2) @(posedge sys_clk);
			irqIn <= 16'h0020;
			ioW(pmp_pkg::ADDR_CMD_MST, cmds[i]);
			@(negedge sys_clk);
			`CHK("intReq", ok[i], intReq[0]);
			ioR(pmp_pkg::ADDR_CMD_MST);
			`CHK("poll", ok[i] ? 8'h85 : 8'h00, ok[i] ? rd : {rd[7], 7'h00});
			if (ok[i]) begin
				ioR(pmp_pkg::ADDR_CMD_MST);
				`CHK("ackClr", 8'h00, rd);
			end
			@(posedge sys_clk);
		end
		irqIn       <= 16'h0000;
		inServiceIn <= 16'h2481;
	endtask : t_poll
	task automatic t_irq;
		regW(pmp_pkg::HR_ENABLE, 32'h0);
		regW(pmp_pkg::HR_IOADDR, {20'h0, pmp_pkg::ADDR_TRIG});
		regW(pmp_pkg::HR_READ, 32'h0);
		waitDone(pmp_pkg::EV_RD_DONE);
		`CHK("irqMasked", 1'b0, irq);
		regW(pmp_pkg::HR_ENABLE, 32'h2);
		@(negedge sys_clk);
		`CHK("irqSet", 1'b1, irq);
		regW(pmp_pkg::HR_CLEAR, 32'h3);
		@(negedge sys_clk);
		`CHK("irqClr", 1'b0, irq);
		regR(pmp_pkg::HR_STATUS);
		`CHK("status", 2'h0, s[1:0]);
	endtask : t_irq
	task automatic t_reset;
		ioW(pmp_pkg::ADDR_CMD_MST, 8'h0b);
		ioW(pmp_pkg::ADDR_TRIG, 8'hf8);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		ioR(pmp_pkg::ADDR_CMD_MST);
		`CHK("selAgain", 8'h00, rd);
		ioR(pmp_pkg::ADDR_TRIG);
		`CHK("trigAgain", 8'h00, rd);
	endtask : t_reset
	task automatic t_cascade;
		@(posedge sys_clk);
		irqIn <= 16'h0100;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK("slvReq", 1'b1, intReq[1]);
		`CHK("mstBlk", 1'b0, intReq[0]);
		@(posedge sys_clk);
		irqIn <= 16'h0000;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK("slvIdle", 1'b0, intReq[1]);
	endtask : t_cascade
	task automatic t_freeze;
		@(posedge sys_clk);
		ce <= 1'b0;
		regW(pmp_pkg::HR_CTRL, 32'h1);
		ce <= 1'b1;
		regR(pmp_pkg::HR_CTRL);
		`CHK("frozen", 32'h0, s);
		regW(pmp_pkg::HR_CTRL, 32'h1);
		regR(pmp_pkg::HR_CTRL);
		`CHK("running", 32'h1, s);
		regW(pmp_pkg::HR_CTRL, 32'h0);
	endtask : t_freeze
	task automatic final_report;
		$display("checks %0d errors %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// --------
	// Clock, watchdog, sequence
	// --------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		numErrors++;
		final_report();
	end
	initial begin
		reset       = 1'b1;
		regAddr     = 8'h00;
		regWrData   = 32'h0000_0000;
		regWr       = 1'b0;
		regRd       = 1'b0;
		ce          = 1'b1;
		irqIn       = 16'h0000;
		maskIn      = 16'h0000;
		inServiceIn = 16'h2481;
		numErrors   = 0;
		checkCount  = 0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		regW(pmp_pkg::HR_ENABLE, 32'h3);
		t_defaults();
		t_select();
		lvlChk(8'hff, 8'hf8);
		lvlChk(8'h50, 8'h50);
		lvlChk(8'h00, 8'h00);
		t_poll();
		t_irq();
		t_cascade();
		t_freeze();
		t_reset();
		final_report();
	end
endmodule : test_pic_mask_poll_trigger_ctrl
